// *** gain_scale.sv ***
// Signed multiply by a Q2.14 gain with saturation
`timescale 1ns/1ps
`include "meter_cal_map.svh"

module gain_scale #(
	parameter int W = 32
) (
	// Operand and gain
	input wire logic signed [W-1:0] din,
	input wire logic [15:0] gain,
	// Scaled result
	output logic signed [W-1:0] dout
);

	localparam logic signed [W+16:0] MAXV = {{18{1'b0}}, {(W-1){1'b1}}};
	localparam logic signed [W+16:0] MINV = ~MAXV;

	logic signed [W+16:0] prod;
	logic signed [W+16:0] shifted;

	always_comb begin
		prod = din * $signed({1'b0, gain});
		shifted = prod >>> `CAL_GAIN_FRAC;
		// A gain just under 2 can push past full scale
		if (shifted > MAXV)
			dout = MAXV[W-1:0];
		else if (shifted < MINV)
			dout = MINV[W-1:0];
		else
			dout = shifted[W-1:0];
	end

endmodule // gain_scale

// *** host_model.sv ***
// Host model that loads calibration constants over the register port
`timescale 1ns/1ps
module host_model #(
	parameter int SETTLE = 4
) (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines flip so a stale value never passes
	task automatic drop();
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~reg_addr;
		reg_wdata <= ~reg_wdata;
	endtask
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		logic g;
		g = a[7:4] != 4'h3 && a[3:0] < 4'h3;
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= g ? {1'b0, d[14:0]} : d;
		reg_wr <= 1'b1;
		@(posedge clk);
		drop();
		if (g) repeat (SETTLE) @(posedge clk);
	endtask
	task automatic read(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		drop();
	endtask
	task automatic write_angle(input logic [7:0] a, input logic [15:0] m, input logic cap);
		write(a, cap ? 16'h0000 - m : m);
	endtask
endmodule // host_model

// *** meter_cal_map.svh ***
// Register map, field positions and reset values of the calibration stage
`ifndef METER_CAL_MAP_SVH
`define METER_CAL_MAP_SVH

// ----------------------------------------------------------------------
// Address split: page in addr[7:4], register index in addr[3:0]
// ----------------------------------------------------------------------
`define CAL_PAGE_MSB 7
`define CAL_PAGE_LSB 4
`define CAL_IDX_MSB 3
`define CAL_IDX_LSB 0
`define CAL_GLOBAL_PAGE 4'h3

// ----------------------------------------------------------------------
// Per-phase page (pages 0..2 are phases A..C)
// ----------------------------------------------------------------------
`define CAL_VGAIN_IDX 4'h0
`define CAL_IGAIN_IDX 4'h1
`define CAL_PGAIN_IDX 4'h2
`define CAL_PT0_IDX 4'h3
`define CAL_PT1_IDX 4'h4
`define CAL_PT2_IDX 4'h5
`define CAL_STAT_IDX 4'h6

// Status word fields
`define CAL_STAT_PT_LSB 0
`define CAL_STAT_CAP_BIT 2

// ----------------------------------------------------------------------
// Global page
// ----------------------------------------------------------------------
`define CAL_LIM_LO_IDX 4'h0
`define CAL_LIM_HI_IDX 4'h1

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define CAL_UNITY_GAIN 16'h4000
`define CAL_POINT_RESET 16'h0000
`define CAL_LIMIT_RESET 16'h0000
`define CAL_GAIN_FRAC 14
`define CAL_LIMIT_SHIFT 8

`endif

// *** meter_cal_pkg.sv ***
// Types shared by the calibration stage
package meter_cal_pkg;

	typedef struct packed {
		logic [31:0] v_rms;
		logic [31:0] i_rms;
		logic signed [31:0] p_real;
		logic signed [31:0] p_reac;
	} raw_meas_t;

	typedef struct packed {
		logic [15:0] vgain;
		logic [15:0] igain;
		logic [15:0] pgain;
		logic [15:0] point0;
		logic [15:0] point1;
		logic [15:0] point2;
	} phase_cfg_t;

	typedef enum logic [1:0] {
		COMP_POINT0,
		COMP_POINT1,
		COMP_POINT2
	} comp_point_t;

	typedef struct packed {
		logic [31:0] voltage_rms_result;
		logic [31:0] current_rms_result;
		logic signed [31:0] real_energy_accum;
		logic signed [31:0] reactive_energy_accum;
		logic signed [15:0] phase_comp_angle;
		comp_point_t comp_point;
		logic load_capacitive;
	} cal_result_t;

endpackage

// *** meter_gain_phase_calibration.sv ***
// Per-phase gain and phase-angle calibration stage with its register port
`timescale 1ns/1ps
`include "meter_cal_map.svh"

// Contract
// (RULE1) Gain 0x4000 means no correction
// (RULE2) Result scaled by gain over 2^14
// (RULE3) Host keeps gain MSB at zero
// (RULE4) Host waits seconds before rereading results; host_model waits only SETTLE clock cycles, and only after gain writes
// (RULE5) Host reloads constants after every reset
// (RULE6) Phase value is radians times 65536
// (RULE7) Reactive energy signed, MSB means capacitive
// (RULE8) Zero limits apply point zero everywhere
// (RULE9) Three points chosen by two current limits
// (RULE10) Power gain trims power on top
// (RULE11) Each phase uses only its settings
// (RULE12) Host writes negative value for capacitive
// (RULE13) 16-bit settings take effect next frame
module meter_gain_phase_calibration #(
	parameter int PHASES = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Measurement frames
	input wire logic frame_tick,
	input meter_cal_pkg::raw_meas_t raw [PHASES],
	output meter_cal_pkg::cal_result_t result [PHASES]
);

	// ------------------------------------------------------------------
	// Settings registers
	// ------------------------------------------------------------------
	meter_cal_pkg::phase_cfg_t cfg_q [PHASES];
	meter_cal_pkg::phase_cfg_t cfg_d [PHASES];
	meter_cal_pkg::cal_result_t res_q [PHASES];
	meter_cal_pkg::cal_result_t res_d [PHASES];
	logic [15:0] lim_lo_q, lim_lo_d;
	logic [15:0] lim_hi_q, lim_hi_d;
	logic [15:0] rdata_q, rdata_d;
	logic [3:0] page;
	logic [3:0] idx;

	assign page = reg_addr[`CAL_PAGE_MSB:`CAL_PAGE_LSB];
	assign idx = reg_addr[`CAL_IDX_MSB:`CAL_IDX_LSB];

	always_comb begin
		cfg_d = cfg_q;
		lim_lo_d = lim_lo_q;
		lim_hi_d = lim_hi_q;
		// Only the addressed phase's page is touched
		if (reg_wr) begin // RULE11
			if (page == `CAL_GLOBAL_PAGE) begin
				if (idx == `CAL_LIM_LO_IDX)
					lim_lo_d = reg_wdata;
				else if (idx == `CAL_LIM_HI_IDX)
					lim_hi_d = reg_wdata;
			end else if (32'(page) < PHASES) begin
				case (idx)
					`CAL_VGAIN_IDX: cfg_d[page[1:0]].vgain = reg_wdata;
					`CAL_IGAIN_IDX: cfg_d[page[1:0]].igain = reg_wdata;
					`CAL_PGAIN_IDX: cfg_d[page[1:0]].pgain = reg_wdata;
					`CAL_PT0_IDX: cfg_d[page[1:0]].point0 = reg_wdata;
					`CAL_PT1_IDX: cfg_d[page[1:0]].point1 = reg_wdata;
					`CAL_PT2_IDX: cfg_d[page[1:0]].point2 = reg_wdata;
					default: ;
				endcase
			end
		end
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			if (page == `CAL_GLOBAL_PAGE) begin
				if (idx == `CAL_LIM_LO_IDX)
					rdata_d = lim_lo_q;
				else if (idx == `CAL_LIM_HI_IDX)
					rdata_d = lim_hi_q;
			end else if (32'(page) < PHASES) begin
				case (idx)
					`CAL_VGAIN_IDX: rdata_d = cfg_q[page[1:0]].vgain;
					`CAL_IGAIN_IDX: rdata_d = cfg_q[page[1:0]].igain;
					`CAL_PGAIN_IDX: rdata_d = cfg_q[page[1:0]].pgain;
					`CAL_PT0_IDX: rdata_d = cfg_q[page[1:0]].point0;
					`CAL_PT1_IDX: rdata_d = cfg_q[page[1:0]].point1;
					`CAL_PT2_IDX: rdata_d = cfg_q[page[1:0]].point2;
					`CAL_STAT_IDX: begin
						rdata_d[`CAL_STAT_PT_LSB +: 2] = res_q[page[1:0]].comp_point;
						rdata_d[`CAL_STAT_CAP_BIT] = res_q[page[1:0]].load_capacitive;
					end
					default: ;
				endcase
			end
		end
	end

	// Constants do not survive reset; host must reload them
	always_ff @(posedge clk) begin // RULE5
		if (srst) begin
			for (int p = 0; p < PHASES; p++) begin
				cfg_q[p] <= {`CAL_UNITY_GAIN, `CAL_UNITY_GAIN, `CAL_UNITY_GAIN, // RULE1
					`CAL_POINT_RESET, `CAL_POINT_RESET, `CAL_POINT_RESET};
			end
			lim_lo_q <= `CAL_LIMIT_RESET;
			lim_hi_q <= `CAL_LIMIT_RESET;
			rdata_q <= 16'h0000;
		end else begin
			cfg_q <= cfg_d;
			lim_lo_q <= lim_lo_d;
			lim_hi_q <= lim_hi_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------------
	// Per-phase correction
	// ------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	for (genvar p = 0; p < PHASES; p++) begin : g_phase
		logic [32:0] v_sc, i_sc;
		logic signed [31:0] pr1, pr2, pr3, pq1, pq2, pq3;
		logic [23:0] cur_lvl;
		logic hi_on, lo_on;

		// Voltage and current gains, then power gain on top
		gain_scale #(.W(33)) u_v (.din({1'b0, raw[p].v_rms}), .gain(cfg_q[p].vgain), .dout(v_sc));
		gain_scale #(.W(33)) u_i (.din({1'b0, raw[p].i_rms}), .gain(cfg_q[p].igain), .dout(i_sc));
		gain_scale #(.W(32)) u_pr1 (.din(raw[p].p_real), .gain(cfg_q[p].vgain), .dout(pr1));
		gain_scale #(.W(32)) u_pr2 (.din(pr1), .gain(cfg_q[p].igain), .dout(pr2));
		gain_scale #(.W(32)) u_pr3 (.din(pr2), .gain(cfg_q[p].pgain), .dout(pr3)); // RULE10
		gain_scale #(.W(32)) u_pq1 (.din(raw[p].p_reac), .gain(cfg_q[p].vgain), .dout(pq1));
		gain_scale #(.W(32)) u_pq2 (.din(pq1), .gain(cfg_q[p].igain), .dout(pq2));
		gain_scale #(.W(32)) u_pq3 (.din(pq2), .gain(cfg_q[p].pgain), .dout(pq3)); // RULE10

		// Limits count in 1/2^24 of full scale, results in 1/2^32
		assign cur_lvl = i_sc[31:`CAL_LIMIT_SHIFT];
		// A zero limit is treated as switched off
		assign lo_on = (lim_lo_q != 16'h0000) && (cur_lvl >= {8'h00, lim_lo_q}); // RULE8
		assign hi_on = (lim_hi_q != 16'h0000) && (cur_lvl >= {8'h00, lim_hi_q}); // RULE8

		always_comb begin
			res_d[p] = res_q[p];
			// Results only move at a frame, so a write lands on the next one
			if (frame_tick) begin // RULE13
				res_d[p].voltage_rms_result = v_sc[31:0]; // RULE2
				res_d[p].current_rms_result = i_sc[31:0]; // RULE2
				res_d[p].real_energy_accum = res_q[p].real_energy_accum + pr3;
				res_d[p].reactive_energy_accum = res_q[p].reactive_energy_accum + pq3;
				res_d[p].load_capacitive = res_d[p].reactive_energy_accum[31]; // RULE7
				// Angle word passes through untouched: radians scaled by 65536
				if (hi_on) begin // RULE9
					res_d[p].comp_point = meter_cal_pkg::COMP_POINT2;
					res_d[p].phase_comp_angle = cfg_q[p].point2; // RULE6
				end else if (lo_on) begin
					res_d[p].comp_point = meter_cal_pkg::COMP_POINT1;
					res_d[p].phase_comp_angle = cfg_q[p].point1;
				end else begin
					res_d[p].comp_point = meter_cal_pkg::COMP_POINT0;
					res_d[p].phase_comp_angle = cfg_q[p].point0;
				end
			end
		end

		always_ff @(posedge clk) begin
			if (srst)
				res_q[p] <= '0;
			else
				res_q[p] <= res_d[p];
		end

		assign result[p] = res_q[p];

		// --------------------------------------------------------------
		// Checks
		// --------------------------------------------------------------
		sequence s_vgain_write;
			reg_wr && page == 4'(p) && idx == `CAL_VGAIN_IDX;
		endsequence

		sequence s_quiet_frame;
			frame_tick && !reg_wr && raw[p].v_rms < 32'h4000_0000;
		endsequence

		a_unity_voltage: assert property (frame_tick && cfg_q[p].vgain == `CAL_UNITY_GAIN
			|=> res_q[p].voltage_rms_result == $past(raw[p].v_rms)) // RULE1
			else $error("unity gain changed the voltage result");

		a_current_scale: assert property (frame_tick && raw[p].i_rms < 32'h4000_0000
			|=> 48'(res_q[p].current_rms_result) ==
			((48'($past(raw[p].i_rms)) * 48'($past(cfg_q[p].igain))) >> 14)) // RULE2
			else $error("current result not scaled by gain over 2^14");

		a_gain_next_frame: assert property (s_vgain_write ##1 s_quiet_frame
			|=> 48'(res_q[p].voltage_rms_result) ==
			((48'($past(raw[p].v_rms)) * 48'($past(reg_wdata, 2))) >> 14)) // RULE13
			else $error("new voltage gain not applied at next frame");

		a_hold_between: assert property (!frame_tick |=> $stable(res_q[p])) // RULE13
			else $error("result moved without a frame");

		a_sign_capacitive: assert property (res_q[p].load_capacitive
			== res_q[p].reactive_energy_accum[31]) // RULE7
			else $error("capacitive flag disagrees with reactive sign");

		a_zero_limits: assert property (frame_tick && lim_lo_q == 16'h0000 && lim_hi_q == 16'h0000
			|=> res_q[p].phase_comp_angle == $past(cfg_q[p].point0)) // RULE8
			else $error("zero limits did not select point zero");

		a_uniform_points: assert property (frame_tick && cfg_q[p].point0 == cfg_q[p].point1
			&& cfg_q[p].point1 == cfg_q[p].point2
			|=> res_q[p].phase_comp_angle == $past(cfg_q[p].point2)) // RULE9
			else $error("equal points gave a different angle");

		a_power_unity: assert property (frame_tick && cfg_q[p].vgain == `CAL_UNITY_GAIN
			&& cfg_q[p].igain == `CAL_UNITY_GAIN && cfg_q[p].pgain == `CAL_UNITY_GAIN
			|=> res_q[p].real_energy_accum ==
			$past(res_q[p].real_energy_accum) + $past(raw[p].p_real)) // RULE10
			else $error("unity gains changed real energy");

		a_phase_isolated: assert property (reg_wr && page != 4'(p) && !frame_tick
			|=> $stable(cfg_q[p])) // RULE11
			else $error("write to another page changed this phase");
	end

endmodule // meter_gain_phase_calibration

// *** testbench.sv ***
// Self-checking bench for the gain and phase calibration stage
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic frame_tick = 1'b0;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_wr;
	logic reg_rd;
	meter_cal_pkg::raw_meas_t raw [3];
	meter_cal_pkg::cal_result_t result [3];
	logic [15:0] cfg [64];
	logic [15:0] saved [64];
	logic [15:0] stat [3];
	logic signed [31:0] acc_r [3];
	logic signed [31:0] acc_q [3];
	logic [15:0] exp_reg [$];
	meter_cal_pkg::cal_result_t exp_res [$];
	logic rd_seen = 1'b0;
	logic tick_seen = 1'b0;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	meter_gain_phase_calibration #(.PHASES(3)) meter_gain_phase_calibration_inst (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_tick(frame_tick), .raw(raw), .result(result));
	host_model #(.SETTLE(4)) host_model_inst (.clk(clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

	// ----
	// Reference arithmetic
	// ----
	function automatic logic [31:0] rms(input logic [31:0] x, input logic [15:0] g);
		longint unsigned v;
		v = (longint'(x) * g) >> 14;
		return (v > 64'hFFFFFFFF) ? 32'hFFFFFFFF : v[31:0];
	endfunction
	function automatic logic signed [31:0] pw(input logic signed [31:0] x, input logic [15:0] g);
		longint v;
		v = (longint'(x) * longint'(g)) >>> 14;
		if (v > 64'sh7FFFFFFF) v = 64'sh7FFFFFFF;
		if (v < -64'sh80000000) v = -64'sh80000000;
		return v[31:0];
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		return (a[7:4] < 4'h3 && a[3:0] < 4'h6) || a == 8'h30 || a == 8'h31;
	endfunction
	function automatic logic [15:0] expv(input logic [7:0] a);
		if (mapped(a)) return cfg[a[5:0]];
		if (a[7:4] < 4'h3 && a[3:0] == 4'h6) return stat[a[5:4]];
		return 16'h0000;
	endfunction
	task automatic clear();
		for (int i = 0; i < 64; i++) cfg[i] = (i < 48 && i % 16 < 3) ? 16'h4000 : 16'h0000;
		for (int p = 0; p < 3; p++) begin
			acc_r[p] = 0;
			acc_q[p] = 0;
			stat[p] = 16'h0000;
		end
	endtask

	// ----
	// Drivers
	// ----
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		if (mapped(a)) cfg[a[5:0]] = d;
		host_model_inst.write(a, d);
	endtask
	task automatic get(input logic [7:0] a);
		exp_reg.push_back(expv(a));
		host_model_inst.read(a);
	endtask
	task automatic dump();
		for (int a = 0; a < 64; a++) get(a[7:0]);
	endtask
	task automatic frame(input logic [31:0] cur);
		meter_cal_pkg::raw_meas_t r;
		meter_cal_pkg::cal_result_t e;
		int b;
		int pt;
		@(posedge clk);
		for (int p = 0; p < 3; p++) begin
			b = p * 16;
			r = {(cur != 0) ? cur : $urandom, (cur != 0) ? cur : $urandom, $urandom, $urandom};
			e.voltage_rms_result = rms(r.v_rms, cfg[b]);
			e.current_rms_result = rms(r.i_rms, cfg[b+1]);
			acc_r[p] += pw(pw(pw(r.p_real, cfg[b]), cfg[b+1]), cfg[b+2]);
			acc_q[p] += pw(pw(pw(r.p_reac, cfg[b]), cfg[b+1]), cfg[b+2]);
			e.real_energy_accum = acc_r[p];
			e.reactive_energy_accum = acc_q[p];
			pt = (cfg[49] != 0 && e.current_rms_result[31:8] >= cfg[49]) ? 2 :
				(cfg[48] != 0 && e.current_rms_result[31:8] >= cfg[48]) ? 1 : 0;
			e.comp_point = meter_cal_pkg::comp_point_t'(pt);
			e.phase_comp_angle = cfg[b+3+pt];
			e.load_capacitive = acc_q[p][31];
			stat[p] = {13'h0000, e.load_capacitive, e.comp_point};
			exp_res.push_back(e);
			raw[p] <= r;
		end
		frame_tick <= 1'b1;
		@(posedge clk);
		frame_tick <= 1'b0;
	endtask

	// ----
	// Checking
	// ----
	task automatic cmp_reg(input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR reg_rdata expected %h seen %h", e, s);
		end
	endtask
	task automatic cmp_res(input int p, input meter_cal_pkg::cal_result_t e,
		input meter_cal_pkg::cal_result_t s);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR result %0d expected %h seen %h", p, e, s);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		rd_seen <= reg_rd;
		tick_seen <= frame_tick;
		cycles++;
		if (rd_seen) cmp_reg(exp_reg.pop_front(), reg_rdata);
		if (tick_seen) begin
			for (int p = 0; p < 3; p++) begin
				cmp_res(p, exp_res.pop_front(), result[p]);
			end
		end
		if (cycles == 6000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial begin
		void'($urandom(177));
		for (int p = 0; p < 3; p++) raw[p] = '0;
		clear();
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		dump();
		frame(0);
		$display("Test reset_unity done");
		for (int p = 0; p < 3; p++) begin
			for (int k = 0; k < 6; k++) begin
				put(8'(p * 16 + k), (k < 3) ? 16'($urandom_range(16'h7FFF, 0)) : 16'($urandom));
			end
		end
		frame(0);
		frame(0);
		dump();
		$display("Test phase_gains done");
		for (int p = 0; p < 3; p++) put(8'(p * 16 + 1), 16'h4000);
		put(8'h30, 16'h0100);
		put(8'h31, 16'h1000);
		host_model_inst.write_angle(8'h03, 16'h023C, 1'b1);
		cfg[3] = 16'hFDC4;
		frame(32'h0000FF00);
		frame(32'h00010000);
		frame(32'h00100000);
		put(8'h27, 16'hBEEF);
		dump();
		$display("Test current_points done");
		saved = cfg;
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		clear();
		dump();
		for (int a = 0; a < 64; a++) if (mapped(a[7:0])) put(a[7:0], saved[a]);
		frame(32'h00010000);
		// Gain write one cycle ahead of a frame must land on that frame
		fork
			put(8'h00, 16'h3EA1);
			begin
				@(posedge clk);
				frame(32'h00010000);
			end
		join
		dump();
		$display("Test reset_reload done");
		// Let the last read and frame results reach the checker
		repeat (3) @(posedge clk);
		if (exp_reg.size() != 0 || exp_res.size() != 0) begin
			bad_count++;
			$display("ERROR pending_notes expected 0 seen %0d", exp_reg.size() + exp_res.size());
		end
		tally_and_finish();
	end
endmodule // testbench
